// File: logic/acc_bank_pkg.sv
// Package: constants and carriers for the secondary accumulator bank
package acc_bank_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int HALF_W = 16;
  localparam int EXT_W  = 4;
  localparam int ACC_W  = 36;

  // ************************************************************
  // Register map (bank slave, word aligned byte addresses)
  // ************************************************************
  localparam logic [7:0] OFS_B0_HIGH   = 8'h00;
  localparam logic [7:0] OFS_B0_LOW    = 8'h04;
  localparam logic [7:0] OFS_B1_HIGH   = 8'h08;
  localparam logic [7:0] OFS_B1_LOW    = 8'h0c;
  localparam logic [7:0] OFS_SHIFT_AMT = 8'h10;
  localparam logic [7:0] OFS_STATUS    = 8'h14;
  localparam logic [7:0] OFS_B0_EXT    = 8'h18;
  localparam logic [7:0] OFS_B1_EXT    = 8'h1c;

  // Status word zero bit positions
  localparam int ST_EXT_BIT   = 0;
  localparam int ST_OVF_BIT   = 1;
  localparam int ST_LIMIT_BIT = 2;
  localparam int ST_SATD_BIT  = 3;

  // ************************************************************
  // Reset values and saturation words
  // ************************************************************
  localparam logic [35:0] ACC_RESET   = 36'h0_0000_0000;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
  localparam logic [15:0] SAT_HI_POS  = 16'h7fff;
  localparam logic [15:0] SAT_HI_NEG  = 16'h8000;
  localparam logic [15:0] SAT_LO_POS  = 16'hffff;
  localparam logic [15:0] SAT_LO_NEG  = 16'h0000;
  localparam logic [35:0] LIM_POS     = 36'h0_7fff_ffff;
  localparam logic [35:0] LIM_NEG     = 36'hf_8000_0000;

  // ************************************************************
  // Operation codes from the core sequencer
  // ************************************************************
  typedef enum logic [3:0] {
    OP_NONE      = 4'h0,
    OP_LOAD_HIGH = 4'h1,
    OP_LOAD_LOW  = 4'h2,
    OP_SHIFT_LD  = 4'h3,
    OP_SWAP      = 4'h4,
    OP_LIMIT     = 4'h5,
    OP_EXP       = 4'h6,
    OP_SV_WRITE  = 4'h7
  } op_t;

  typedef struct packed {
    logic        valid;
    op_t         op;
    logic        sel;
    logic [15:0] data;
  } core_cmd_t;

  typedef struct packed {
    logic        valid;
    logic        ext;
    logic        ovf;
  } alu_flags_t;

endpackage

// File: logic/acc_bank.sv
// Secondary accumulator bank with sign extension, swap, flags and saturation
//
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Each accumulator is 16-bit high, 16-bit low and 4-bit extension, 36 bits
// - High and low halves read and written singly as 16-bit operands
// - Swap exchanges secondary and primary contents in one cycle
// - Either accumulator feeds exponent unit and shifter, and takes shifter result
// - Shifter result significant past bit 31 sets extension flag
// - Sign lost beyond shifter or nibble top sets overflow and sticky limit
// - Extension nibble reached only via shift load or swap
// - Narrow writes to high half are sign-extended; narrow writes to low half zero the other 20 bits
// - Loading high clears low; loading low clears high
// - All 36 bits load in one cycle by shift or swap
// - 16-bit shift amount register supplies run-time shift count
// - Each exponent result is written into shift amount register
// - Shift amount register also serves as general temporary register
// - Saturate on half moved to bus and on limit instruction
// - Saturated value is maximum magnitude with source sign
// - Move saturation limits bus word only, accumulator unchanged
// - High half 7fff or 8000; low half ffff or 0000
// - Decision uses current contents at transfer time
// - Flags update from bit-field, ALU and shifter operations
// - Saturation-disable bit suppresses move saturation; limiting sets limit flag
// - After swap, moved-out half still saturated correctly
module acc_bank
(
  input  wire logic                      ref_clk_in,
  input  wire logic                      nrst_in,
  input  wire acc_bank_pkg::core_cmd_t   cmd_in,
  input  wire logic [35:0]               shifter_result_in,
  input  wire logic                      shifter_ext_in,
  input  wire logic                      shifter_ovf_in,
  input  wire logic [15:0]               exp_result_in,
  input  wire logic [35:0]               acc_a_in,
  input  wire acc_bank_pkg::alu_flags_t  alu_flags_in,
  input  wire logic                      rd_valid_in,
  input  wire logic                      rd_sel_in,
  input  wire logic                      rd_high_in,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [7:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  output logic      [15:0]               main_data_bus_out,
  output logic      [35:0]               acc_b_to_a_out,
  output logic      [35:0]               exp_src_out,
  output logic      [35:0]               shifter_src_out,
  output logic      [15:0]               shift_amount_out,
  output logic      [3:0]                status_word_zero_out
);

  // ************************************************************
  // State
  // ************************************************************
  logic [35:0] acc_reg [2];
  logic [15:0] shift_amount_reg;
  logic        ext_flag_reg;
  logic        ovf_flag_reg;
  logic        limit_flag_reg;
  logic        saturation_disable_bit;
  logic        ack_reg;

  acc_bank_pkg::op_t op;
  logic              sel;
  logic [15:0]       dat;
  logic              bus_wr;
  logic              bus_rd;
  logic              limit_hit;
  logic              move_lim_hit;
  logic [15:0]       move_word;

  assign op     = cmd_in.valid ? cmd_in.op : acc_bank_pkg::OP_NONE;
  assign sel    = cmd_in.sel;
  assign dat    = cmd_in.data;
  assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg && wb_sel_i[0] && wb_sel_i[1];
  assign bus_rd = wb_cyc_i && wb_stb_i && !ack_reg;

  // ************************************************************
  // Helpers
  // ************************************************************
  // Overflow into nibble: bits 35..31 not all equal
  function automatic logic over_32(input logic [35:0] v);
    over_32 = !((&v[35:31]) || !(|v[35:31]));
  endfunction

  // Saturating read of one half; returns {hit, word}
  function automatic logic [16:0] sat_half(input logic [35:0] v, input logic high,
                                           input logic dis);
    logic neg;
    neg = v[35];
    if (!dis && over_32(v))
    begin
      if (high)
        sat_half = {1'b1, neg ? acc_bank_pkg::SAT_HI_NEG : acc_bank_pkg::SAT_HI_POS};
      else
        sat_half = {1'b1, neg ? acc_bank_pkg::SAT_LO_NEG : acc_bank_pkg::SAT_LO_POS};
    end
    else
      sat_half = {1'b0, high ? v[31:16] : v[15:0]};
  endfunction

  // ************************************************************
  // Accumulators
  // ************************************************************
  assign limit_hit = (op == acc_bank_pkg::OP_LIMIT) && over_32(acc_reg[sel]);

  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      acc_reg[0] <= acc_bank_pkg::ACC_RESET;
      acc_reg[1] <= acc_bank_pkg::ACC_RESET;
    end
    else if (bus_wr && wb_adr_i == acc_bank_pkg::OFS_B0_HIGH)
      acc_reg[0] <= {{4{wb_dat_i[15]}}, wb_dat_i[15:0], 16'h0000};
    else if (bus_wr && wb_adr_i == acc_bank_pkg::OFS_B0_LOW)
      acc_reg[0] <= {20'h00000, wb_dat_i[15:0]};
    else if (bus_wr && wb_adr_i == acc_bank_pkg::OFS_B1_HIGH)
      acc_reg[1] <= {{4{wb_dat_i[15]}}, wb_dat_i[15:0], 16'h0000};
    else if (bus_wr && wb_adr_i == acc_bank_pkg::OFS_B1_LOW)
      acc_reg[1] <= {20'h00000, wb_dat_i[15:0]};
    else
    begin
      case (op)
        acc_bank_pkg::OP_LOAD_HIGH:
          acc_reg[sel] <= {{4{dat[15]}}, dat, 16'h0000};
        acc_bank_pkg::OP_LOAD_LOW:
          acc_reg[sel] <= {20'h00000, dat};
        acc_bank_pkg::OP_SHIFT_LD:
          acc_reg[sel] <= shifter_result_in;
        acc_bank_pkg::OP_SWAP:
          acc_reg[sel] <= acc_a_in;
        acc_bank_pkg::OP_LIMIT:
          if (limit_hit)
            acc_reg[sel] <= acc_reg[sel][35] ? acc_bank_pkg::LIM_NEG
                                             : acc_bank_pkg::LIM_POS;
        default:
          acc_reg[sel] <= acc_reg[sel];
      endcase
    end
  end

  // Swap partner sees the old contents in the same cycle
  assign acc_b_to_a_out  = acc_reg[sel];
  assign exp_src_out     = acc_reg[sel];
  assign shifter_src_out = acc_reg[sel];

  // ************************************************************
  // Shift amount register
  // ************************************************************
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      shift_amount_reg <= acc_bank_pkg::SHIFT_RESET;
    else if (bus_wr && wb_adr_i == acc_bank_pkg::OFS_SHIFT_AMT)
      shift_amount_reg <= wb_dat_i[15:0];
    else if (op == acc_bank_pkg::OP_EXP)
      shift_amount_reg <= exp_result_in;
    else if (op == acc_bank_pkg::OP_SV_WRITE)
      shift_amount_reg <= dat;
  end

  assign shift_amount_out = shift_amount_reg;

  // ************************************************************
  // Move-out saturation on the data bus
  // ************************************************************
  // Decided from live contents so late moves and post-swap moves still limit
  assign {move_lim_hit, move_word} = sat_half(acc_reg[rd_sel_in], rd_high_in,
                                              saturation_disable_bit);

  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      main_data_bus_out <= 16'h0000;
    else if (rd_valid_in)
      main_data_bus_out <= move_word;
  end

  // ************************************************************
  // Status flags
  // ************************************************************
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ext_flag_reg           <= 1'b0;
      ovf_flag_reg           <= 1'b0;
      saturation_disable_bit <= 1'b0;
    end
    else if (bus_wr && wb_adr_i == acc_bank_pkg::OFS_STATUS)
    begin
      ext_flag_reg           <= wb_dat_i[acc_bank_pkg::ST_EXT_BIT];
      ovf_flag_reg           <= wb_dat_i[acc_bank_pkg::ST_OVF_BIT];
      saturation_disable_bit <= wb_dat_i[acc_bank_pkg::ST_SATD_BIT];
    end
    else if (op == acc_bank_pkg::OP_SHIFT_LD)
    begin
      ext_flag_reg <= shifter_ext_in || over_32(shifter_result_in);
      ovf_flag_reg <= shifter_ovf_in;
    end
    else if (alu_flags_in.valid)
    begin
      ext_flag_reg <= alu_flags_in.ext;
      ovf_flag_reg <= alu_flags_in.ovf;
    end
  end

  // Sticky: a set in the same cycle as a software clear wins
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      limit_flag_reg <= 1'b0;
    else if ((op == acc_bank_pkg::OP_SHIFT_LD && shifter_ovf_in) ||
             (alu_flags_in.valid && alu_flags_in.ovf) || limit_hit ||
             (rd_valid_in && move_lim_hit))
      limit_flag_reg <= 1'b1;
    else if (bus_wr && wb_adr_i == acc_bank_pkg::OFS_STATUS)
      limit_flag_reg <= wb_dat_i[acc_bank_pkg::ST_LIMIT_BIT];
  end

  assign status_word_zero_out = {saturation_disable_bit, limit_flag_reg,
                                 ovf_flag_reg, ext_flag_reg};

  // ************************************************************
  // Wishbone slave, registered one-cycle ack after one wait cycle
  // ************************************************************
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      ack_reg <= 1'b0;
    else
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      wb_dat_o <= 32'h0000_0000;
    else if (bus_rd)
    begin
      if (wb_adr_i == acc_bank_pkg::OFS_B0_HIGH)
        wb_dat_o <= {16'h0000, acc_reg[0][31:16]};
      else if (wb_adr_i == acc_bank_pkg::OFS_B0_LOW)
        wb_dat_o <= {16'h0000, acc_reg[0][15:0]};
      else if (wb_adr_i == acc_bank_pkg::OFS_B1_HIGH)
        wb_dat_o <= {16'h0000, acc_reg[1][31:16]};
      else if (wb_adr_i == acc_bank_pkg::OFS_B1_LOW)
        wb_dat_o <= {16'h0000, acc_reg[1][15:0]};
      else if (wb_adr_i == acc_bank_pkg::OFS_SHIFT_AMT)
        wb_dat_o <= {16'h0000, shift_amount_reg};
      else if (wb_adr_i == acc_bank_pkg::OFS_STATUS)
        wb_dat_o <= {28'h0000000, status_word_zero_out};
      else
        wb_dat_o <= 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_reg;

endmodule

`default_nettype wire

// File: testbench/acc_bank_properties.sv
// Checker: port-level timing, flag and saturation properties of the accumulator bank
`timescale 1ns/100ps
`default_nettype none
module acc_bank_properties
(
  input wire logic                    ref_clk_in,
  input wire logic                    nrst_in,
  input wire acc_bank_pkg::core_cmd_t cmd_in,
  input wire logic                    shifter_ext_in,
  input wire logic                    shifter_ovf_in,
  input wire logic [15:0]             exp_result_in,
  input wire logic                    rd_valid_in,
  input wire logic                    rd_sel_in,
  input wire logic                    rd_high_in,
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_we_i,
  input wire logic                    wb_ack_o,
  input wire logic [15:0]             main_data_bus_out,
  input wire logic [35:0]             shifter_src_out,
  input wire logic [15:0]             shift_amount_out,
  input wire logic [3:0]              status_word_zero_out
);
  // ****************************************
  // Helpers and properties
  // ****************************************
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!nrst_in);
  logic       quiet;
  logic       mv_ok;
  logic [4:0] top;
  logic [3:0] st;
  // Bus writes win over core ops except limit-flag sets, so only quiet cycles are judged
  assign quiet = !(wb_cyc_i && wb_stb_i && wb_we_i);
  assign top   = shifter_src_out[35:31];
  assign st    = status_word_zero_out;
  assign mv_ok = rd_valid_in && quiet && !cmd_in.valid && rd_sel_in == cmd_in.sel
                 && !st[acc_bank_pkg::ST_SATD_BIT];
  sequence shl;
    cmd_in.valid && cmd_in.op == acc_bank_pkg::OP_SHIFT_LD && quiet;
  endsequence
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  exp_to_shift_a: assert property (cmd_in.valid && cmd_in.op == acc_bank_pkg::OP_EXP && quiet
    |=> shift_amount_out == $past(exp_result_in)) else $error("exponent lost");
  limit_hold_a: assert property (st[acc_bank_pkg::ST_LIMIT_BIT] && quiet
    |=> st[acc_bank_pkg::ST_LIMIT_BIT]) else $error("limit cleared");
  ext_flag_a: assert property (shl ##0 shifter_ext_in |=> st[acc_bank_pkg::ST_EXT_BIT])
    else $error("ext flag missing");
  ovf_latch_a: assert property (shl ##0 shifter_ovf_in
    |=> st[acc_bank_pkg::ST_OVF_BIT] && st[acc_bank_pkg::ST_LIMIT_BIT]) else $error("ovf");
  sat_high_pos_a: assert property (mv_ok && rd_high_in && !top[4] && top != 5'h00
    |-> ##[1:2] main_data_bus_out == acc_bank_pkg::SAT_HI_POS) else $error("high pos");
  sat_high_neg_a: assert property (mv_ok && rd_high_in && top[4] && top != 5'h1f
    |-> ##[1:2] main_data_bus_out == acc_bank_pkg::SAT_HI_NEG) else $error("high neg");
  sat_low_pos_a: assert property (mv_ok && !rd_high_in && !top[4] && top != 5'h00
    |-> ##[1:2] main_data_bus_out == acc_bank_pkg::SAT_LO_POS) else $error("low pos");
  cover property (mv_ok && rd_high_in);
  cover property (cmd_in.valid && cmd_in.op == acc_bank_pkg::OP_SWAP);
  cover property (wb_ack_o && !wb_we_i);
endmodule
`default_nettype wire

// File: testbench/core_model.sv
// Far side: core sequencer, barrel shifter, exponent unit and primary accumulator
`timescale 1ns/100ps
`default_nettype none
module core_model
(
  input  wire logic                     req_valid_in,
  input  wire logic [3:0]               req_op_in,
  input  wire logic                     req_sel_in,
  input  wire logic [15:0]              req_data_in,
  input  wire logic                     req_alu_in,
  input  wire logic [15:0]              shift_amount_in,
  output var  acc_bank_pkg::core_cmd_t  cmd_out,
  output logic      [35:0]              shifter_result_out,
  output logic                          shifter_ext_out,
  output logic                          shifter_ovf_out,
  output logic      [15:0]              exp_result_out,
  output logic      [35:0]              acc_a_out,
  output var  acc_bank_pkg::alu_flags_t alu_flags_out
);
  // ****************************************
  // Behavioural far side
  // ****************************************
  logic [35:0] operand;
  assign cmd_out = {req_valid_in, req_op_in, req_sel_in, req_data_in};
  // Left shifts only; right shifts are never requested
  assign operand = {{20{req_data_in[15]}}, req_data_in};
  assign shifter_result_out = operand << shift_amount_in[5:0];
  assign shifter_ext_out = |shifter_result_out[35:31] && ~&shifter_result_out[35:31];
  assign shifter_ovf_out = shifter_result_out[35] != req_data_in[15];
  assign exp_result_out = {{10{req_data_in[5]}}, req_data_in[5:0]};
  assign acc_a_out = 36'h9_1234_5678;
  assign alu_flags_out = {req_alu_in, req_data_in[0], req_data_in[1]};
endmodule
`default_nettype wire

// File: testbench/test_acc_bank.sv
// Self-checking testbench of the secondary accumulator bank
`timescale 1ns/100ps
`default_nettype none
module test_acc_bank;
  // ****************************************
  // Stimulus, instances and scenarios
  // ****************************************
  logic ref_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic rv = 1'b0, rs = 1'b0, ra = 1'b0, mv_v = 1'b0, mv_s = 1'b0, mv_h = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]  ro = 4'h0;
  logic [15:0] rd = 16'h0000, bus_word, sv, exr;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000, rdat, wdo;
  logic [35:0] shr, acca, b2a, exs, sh_src;
  logic [3:0]  st;
  logic        she, sho, ack;
  acc_bank_pkg::core_cmd_t  cmd;
  acc_bank_pkg::alu_flags_t aluf;
  int miscompares = 0;
  int n_compared = 0;
  always #4 ref_clk_in = ~ref_clk_in;
  core_model i_core_model (.req_valid_in(rv), .req_op_in(ro), .req_sel_in(rs),
    .req_data_in(rd), .req_alu_in(ra), .shift_amount_in(sv), .cmd_out(cmd),
    .shifter_result_out(shr), .shifter_ext_out(she), .shifter_ovf_out(sho),
    .exp_result_out(exr), .acc_a_out(acca), .alu_flags_out(aluf));
  acc_bank i_acc_bank (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .cmd_in(cmd),
    .shifter_result_in(shr), .shifter_ext_in(she), .shifter_ovf_in(sho),
    .exp_result_in(exr), .acc_a_in(acca), .alu_flags_in(aluf), .rd_valid_in(mv_v),
    .rd_sel_in(mv_s), .rd_high_in(mv_h), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack),
    .main_data_bus_out(bus_word), .acc_b_to_a_out(b2a), .exp_src_out(exs),
    .shifter_src_out(sh_src), .shift_amount_out(sv), .status_word_zero_out(st));
  task automatic chk(input logic [35:0] seen, input logic [35:0] expd);
    n_compared++;
    if (seen !== expd)
    begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask
  // Waits for ack however long it takes; only the watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do
    begin
      @(posedge ref_clk_in);
    end
    while (ack !== 1'b1);
    rdat = wdo;
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic op(input logic [3:0] o, input logic s, input logic [15:0] d);
    @(posedge ref_clk_in);
    {rv, ro, rs, rd} <= {1'b1, o, s, d};
    @(posedge ref_clk_in);
    rv <= 1'b0;
    #1;
  endtask
  // Word is read two edges on, so one or two cycles of latency both pass
  task automatic mv(input logic s, input logic h, input logic [15:0] expd);
    @(posedge ref_clk_in);
    {mv_v, mv_s, mv_h} <= {1'b1, s, h};
    @(posedge ref_clk_in);
    mv_v <= 1'b0;
    @(posedge ref_clk_in);
    #1;
    chk(bus_word, expd);
  endtask
  task automatic halves_test;
    wb(1'b1, acc_bank_pkg::OFS_B0_HIGH, 32'h0000_8123);
    chk(sh_src, 36'hf_8123_0000);
    wb(1'b0, acc_bank_pkg::OFS_B0_HIGH, 32'h0);
    chk(rdat[15:0], 16'h8123);
    wb(1'b1, acc_bank_pkg::OFS_B0_LOW, 32'h0000_5555);
    chk(sh_src, 36'h0_0000_5555);
    wb(1'b1, acc_bank_pkg::OFS_B0_EXT, 32'hffff_ffff);
    wb(1'b0, acc_bank_pkg::OFS_B0_EXT, 32'h0);
    chk(rdat, 32'h0);
    op(acc_bank_pkg::OP_LOAD_HIGH, 1'b0, 16'h8001);
    chk(sh_src, 36'hf_8001_0000);
    op(acc_bank_pkg::OP_LOAD_LOW, 1'b0, 16'h1234);
    chk(sh_src, 36'h0_0000_1234);
  endtask
  task automatic sat_test;
    wb(1'b1, acc_bank_pkg::OFS_SHIFT_AMT, 32'h0000_0011);
    chk(sv, 16'h0011);
    op(acc_bank_pkg::OP_SHIFT_LD, 1'b0, 16'h7fff);
    chk(sh_src, 36'h0_fffe_0000);
    chk(st[acc_bank_pkg::ST_EXT_BIT], 1'b1);
    mv(1'b0, 1'b1, acc_bank_pkg::SAT_HI_POS);
    mv(1'b0, 1'b0, acc_bank_pkg::SAT_LO_POS);
    chk(sh_src, 36'h0_fffe_0000);
    chk(st[acc_bank_pkg::ST_LIMIT_BIT], 1'b1);
    op(acc_bank_pkg::OP_SHIFT_LD, 1'b0, 16'h8000);
    mv(1'b0, 1'b1, acc_bank_pkg::SAT_HI_NEG);
    mv(1'b0, 1'b0, acc_bank_pkg::SAT_LO_NEG);
    wb(1'b1, acc_bank_pkg::OFS_STATUS, 32'h0000_0008);
    mv(1'b0, 1'b1, 16'h0000);
    op(acc_bank_pkg::OP_SHIFT_LD, 1'b0, 16'h7fff);
    op(acc_bank_pkg::OP_LIMIT, 1'b0, 16'h0000);
    chk(sh_src, acc_bank_pkg::LIM_POS);
    wb(1'b1, acc_bank_pkg::OFS_SHIFT_AMT, 32'h0000_0015);
    op(acc_bank_pkg::OP_SHIFT_LD, 1'b0, 16'h4000);
    chk(st[2:1], 2'b11);
  endtask
  task automatic swap_test;
    op(acc_bank_pkg::OP_SWAP, 1'b1, 16'h0000);
    chk(b2a, 36'h9_1234_5678);
    chk(exs, 36'h9_1234_5678);
    wb(1'b1, acc_bank_pkg::OFS_STATUS, 32'h0);
    mv(1'b1, 1'b1, acc_bank_pkg::SAT_HI_NEG);
    op(acc_bank_pkg::OP_EXP, 1'b1, 16'h003b);
    chk(sv, 16'hfffb);
    op(acc_bank_pkg::OP_SV_WRITE, 1'b1, 16'h0042);
    chk(sv, 16'h0042);
    wb(1'b1, acc_bank_pkg::OFS_STATUS, 32'h0);
    @(posedge ref_clk_in);
    {ra, rd} <= {1'b1, 16'h0001};
    @(posedge ref_clk_in);
    ra <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    #1;
    chk(st, 4'h1);
  endtask
  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    halves_test();
    sat_test();
    swap_test();
    conclude();
  end
  initial
  begin
    #20000;
    miscompares++;
    conclude();
  end
endmodule
bind acc_bank acc_bank_properties i_acc_bank_properties (.ref_clk_in(ref_clk_in),
  .nrst_in(nrst_in), .cmd_in(cmd_in), .shifter_ext_in(shifter_ext_in),
  .shifter_ovf_in(shifter_ovf_in), .exp_result_in(exp_result_in), .rd_valid_in(rd_valid_in),
  .rd_sel_in(rd_sel_in), .rd_high_in(rd_high_in), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .main_data_bus_out(main_data_bus_out),
  .shifter_src_out(shifter_src_out), .shift_amount_out(shift_amount_out),
  .status_word_zero_out(status_word_zero_out));
`default_nettype wire
